//--- logic/acs_consts.vh
// constants for the converter channel, reference and sleep control block
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// ==========================================================
// register bus
`define ACS_ADDR_W      3
`define ACS_DATA_W      16
`define ACS_OFS_CTRL    3'h0
`define ACS_OFS_RESULT  3'h1
`define ACS_OFS_STATUS  3'h2
`define ACS_OFS_MASK    3'h3
`define ACS_CTRL_RST    16'h0000

// ==========================================================
// control register fields
`define ACS_CTRL_EN     0
`define ACS_CTRL_START  1
`define ACS_CTRL_FREE   2
`define ACS_CTRL_REF_LO 4
`define ACS_CTRL_REF_HI 5
`define ACS_CTRL_CH_LO  8
`define ACS_CTRL_CH_HI  10

// ==========================================================
// reference source encodings
`define ACS_REF_PIN     2'h0
`define ACS_REF_SUPPLY  2'h1
`define ACS_REF_BANDGAP 2'h3

// ==========================================================
// status / mask bits
`define ACS_EVT_W       2
`define ACS_ST_DONE     0
`define ACS_ST_REFSW    1

// ==========================================================
// sleep mode codes seen from the sleep controller
`define ACS_SLP_IDLE    3'h0
`define ACS_SLP_NOISE   3'h1

// ==========================================================
// converter timing
`define ACS_DIV_W       8
`define ACS_CLK_DIV     8'h10
`define ACS_RES_W       10
`define ACS_FULL_SCALE  10'h3FF
`define ACS_MSB_CODE    10'h200
`define ACS_BIT_ONE     10'h001
`define ACS_MSB_IDX     4'h9
`define ACS_SAMPLE_TICKS 4'h2

`endif

//--- logic/acs_sync2.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module acs_sync2 (
   input  wire clk_sys,
   input  wire rst_n,
   input  wire asyncIn,
   output reg  syncOut
);

   reg stage1_r;   // first stage, read only by the second

   // ==========================================================
   // synchroniser chain
   // only the second stage is ever looked at by logic
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         stage1_r <= 1'b0;
         syncOut  <= 1'b0;
      end else begin
         stage1_r <= asyncIn;
         syncOut  <= stage1_r;
      end
   end

endmodule

`default_nettype wire

//--- logic/acs_adc_ctrl.v
// converter control: channel capture, reference select, SAR sequencer, sleep start
`timescale 1ns/1ps
`default_nettype none
`include "acs_consts.vh"

module acs_adc_ctrl (
   input  wire                      clk_sys,
   input  wire                      rst_n,
   input  wire [`ACS_ADDR_W-1:0]    regAddr,
   input  wire [`ACS_DATA_W-1:0]    regWrData,
   input  wire                      regWrStb,
   input  wire                      regRdStb,
   output reg  [`ACS_DATA_W-1:0]    regRdData,
   output wire                      irq,
   input  wire                      compIn,
   output reg  [2:0]                chanSel,
   output reg  [1:0]                refSel,
   output reg                       sampleHold,
   output reg  [`ACS_RES_W-1:0]     dacCode,
   output reg                       converterPowered,
   input  wire [2:0]                sleepMode,
   input  wire                      cpuHalted
);

   // ==========================================================
   // state encodings
   localparam [1:0] ST_IDLE   = 2'h0;   // waiting for a start
   localparam [1:0] ST_SAMPLE = 2'h1;   // input tracked by sample and hold
   localparam [1:0] ST_CONV   = 2'h2;   // bit-by-bit approximation

   // ==========================================================
   // declarations
   reg  [1:0]             state_r;       // sequencer state
   reg                    startPend_r;   // start accepted, waiting for a tick
   reg  [`ACS_DIV_W-1:0]  divCnt_r;      // converter clock divider
   reg  [3:0]             phaseCnt_r;    // sample phase length in ticks
   reg  [3:0]             bitIdx_r;      // bit under trial
   reg  [`ACS_RES_W-1:0]  result_r;      // last finished result
   reg                    en_r;          // converter enable bit
   reg                    free_r;        // free-running mode
   reg  [2:0]             chan_r;        // channel selection as written
   reg  [`ACS_EVT_W-1:0]  status_r;      // sticky events
   reg  [`ACS_EVT_W-1:0]  mask_r;        // interrupt enables
   reg                    refDirty_r;    // reference changed since last result
   reg                    haltPrev_r;    // cpuHalted one cycle ago

   wire                   compSync;      // comparator after two flops
   wire                   tick;          // one converter clock period
   wire                   busy;          // conversion pending or running
   wire                   wrCtrl;        // control register write
   wire                   swStart;       // software start accepted
   wire                   sleepStart;    // start caused by sleep entry
   wire                   lowPowerMode;  // idle or noise-reduction sleep
   wire                   prepared;      // converter ready for sleep start
   wire                   lastBit;       // final decision in this tick
   wire                   doneEvt;       // result valid this cycle
   wire                   refEvt;        // first result after reference change
   wire [`ACS_RES_W-1:0]  bitMask;       // one-hot of the bit under trial
   wire [`ACS_RES_W-1:0]  decided;       // trial code after the decision
   wire [`ACS_EVT_W-1:0]  events;        // event vector into status
   wire [`ACS_EVT_W-1:0]  clrBits;       // write-one-to-clear bits
   wire [1:0]             wrRef;         // reference field of a write
   wire [2:0]             wrChan;        // channel field of a write
   wire [`ACS_DATA_W-1:0] ctrlRst;       // reset image of the control register, sliced per field

   // ==========================================================
   // comparator input synchroniser
   // the comparator comes from the analog side, so it is retimed
   acs_sync2 u_compSync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .asyncIn (compIn),
      .syncOut (compSync)
   );

   // ==========================================================
   // decode
   assign ctrlRst  = `ACS_CTRL_RST;
   assign wrCtrl   = regWrStb && (regAddr == `ACS_OFS_CTRL);
   assign wrRef    = regWrData[`ACS_CTRL_REF_HI:`ACS_CTRL_REF_LO];
   assign wrChan   = regWrData[`ACS_CTRL_CH_HI:`ACS_CTRL_CH_LO];
   assign busy     = startPend_r || (state_r != ST_IDLE);
   // a start while busy is ignored; it needs the enable in the same write
   assign swStart  = wrCtrl && regWrData[`ACS_CTRL_START] && regWrData[`ACS_CTRL_EN] && !busy;
   assign clrBits  = (regWrStb && (regAddr == `ACS_OFS_STATUS)) ? regWrData[`ACS_EVT_W-1:0]
                                                                : {`ACS_EVT_W{1'b0}};

   // ==========================================================
   // sleep entry start
   // only the rising edge of the halt starts a conversion, so a wake
   // never re-arms a start by itself (the CPU must sleep again)
   assign lowPowerMode = (sleepMode == `ACS_SLP_IDLE) || (sleepMode == `ACS_SLP_NOISE);
   assign prepared     = en_r && !busy && !free_r && mask_r[`ACS_ST_DONE];
   assign sleepStart   = cpuHalted && !haltPrev_r && lowPowerMode && prepared && !swStart;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         haltPrev_r <= 1'b0;
      end else begin
         haltPrev_r <= cpuHalted;
      end
   end

   // ==========================================================
   // converter clock divider
   // runs only while enabled, so a disabled converter is quiet
   assign tick = en_r && (divCnt_r == {`ACS_DIV_W{1'b0}});

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         divCnt_r <= {`ACS_DIV_W{1'b0}};
      end else if (!en_r || tick) begin
         divCnt_r <= `ACS_CLK_DIV - 8'h01;
      end else begin
         divCnt_r <= divCnt_r - 8'h01;
      end
   end

   // ==========================================================
   // control register
   // power follows the enable bit alone; sleep modes never touch it
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         en_r             <= ctrlRst[`ACS_CTRL_EN];
         free_r           <= 1'b0;
         refSel           <= `ACS_REF_PIN;
         chan_r           <= 3'h0;
         refDirty_r       <= 1'b0;
         converterPowered <= 1'b0;
      end else begin
         converterPowered <= en_r;
         if (wrCtrl) begin
            en_r   <= regWrData[`ACS_CTRL_EN];
            free_r <= regWrData[`ACS_CTRL_FREE];
            chan_r <= wrChan;
            // encoding 2 is not a source; keep the pin rather than short anything
            if (wrRef == `ACS_REF_SUPPLY || wrRef == `ACS_REF_BANDGAP) begin
               refSel <= wrRef;
            end else begin
               refSel <= `ACS_REF_PIN;
            end
         end
         // a new reference marks the next result as the settling one
         if (wrCtrl && (wrRef != refSel)) begin
            refDirty_r <= 1'b1;
         end else if (doneEvt) begin
            refDirty_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // sequencer
   assign bitMask = `ACS_BIT_ONE << bitIdx_r;
   // comparator high means input above trial code: keep the bit, so an
   // input above the reference walks up to full scale
   assign decided = compSync ? dacCode : (dacCode & ~bitMask);
   assign lastBit = tick && (state_r == ST_CONV) && (bitIdx_r == 4'h0);
   assign doneEvt = lastBit;
   assign refEvt  = doneEvt && refDirty_r;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r     <= ST_IDLE;
         startPend_r <= 1'b0;
         phaseCnt_r  <= 4'h0;
         bitIdx_r    <= 4'h0;
         dacCode     <= {`ACS_RES_W{1'b0}};
         result_r    <= {`ACS_RES_W{1'b0}};
         chanSel     <= 3'h0;
         sampleHold  <= 1'b0;
      end else if (!en_r) begin
         // disabling aborts any conversion in flight; the trial code
         // returns to zero so an aborted run never looks busy
         state_r     <= ST_IDLE;
         startPend_r <= 1'b0;
         sampleHold  <= 1'b0;
         dacCode     <= {`ACS_RES_W{1'b0}};
      end else begin
         // channel is frozen at the moment the start is taken
         if (swStart) begin
            chanSel     <= wrChan;
            startPend_r <= 1'b1;
         end else if (sleepStart) begin
            chanSel     <= chan_r;
            startPend_r <= 1'b1;
         end
         case (state_r)
            ST_IDLE: begin
               if (tick && startPend_r) begin
                  startPend_r <= 1'b0;
                  state_r     <= ST_SAMPLE;
                  phaseCnt_r  <= `ACS_SAMPLE_TICKS;
                  sampleHold  <= 1'b1;
               end
            end
            ST_SAMPLE: begin
               if (tick) begin
                  if (phaseCnt_r == 4'h1) begin
                     state_r    <= ST_CONV;
                     sampleHold <= 1'b0;
                     bitIdx_r   <= `ACS_MSB_IDX;
                     dacCode    <= `ACS_MSB_CODE;
                  end else begin
                     phaseCnt_r <= phaseCnt_r - 4'h1;
                  end
               end
            end
            ST_CONV: begin
               if (tick) begin
                  if (bitIdx_r == 4'h0) begin
                     // result and flag change on this edge; busy falls here too unless free-running
                     result_r <= decided;
                     dacCode  <= {`ACS_RES_W{1'b0}};
                     if (free_r) begin
                        // restart at once with the channel as it stands now;
                        // a change made during this run lands here
                        chanSel    <= chan_r;
                        state_r    <= ST_SAMPLE;
                        phaseCnt_r <= `ACS_SAMPLE_TICKS;
                        sampleHold <= 1'b1;
                     end else begin
                        state_r <= ST_IDLE;
                     end
                  end else begin
                     bitIdx_r <= bitIdx_r - 4'h1;
                     dacCode  <= decided | (bitMask >> 1);
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // interrupt status and mask
   // a finished conversion always flags, whether or not the CPU has
   // already woken for some other reason
   assign events = {refEvt, doneEvt};

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         status_r <= {`ACS_EVT_W{1'b0}};
         mask_r   <= {`ACS_EVT_W{1'b0}};
      end else begin
         // set wins over a clear in the same cycle
         status_r <= (status_r & ~clrBits) | events;
         if (regWrStb && (regAddr == `ACS_OFS_MASK)) begin
            mask_r <= regWrData[`ACS_EVT_W-1:0];
         end
      end
   end

   // level output; the sleep controller uses it as the wake request
   assign irq = |(status_r & mask_r);

   // ==========================================================
   // register read port
   // data stand one cycle after the strobe and read zero otherwise
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdData <= {`ACS_DATA_W{1'b0}};
      end else if (regRdStb) begin
         case (regAddr)
            `ACS_OFS_CTRL: begin
               regRdData <= {5'h00, chan_r, 2'h0, refSel, 1'b0, free_r, busy, en_r};
            end
            `ACS_OFS_RESULT: begin
               regRdData <= {6'h00, result_r};
            end
            `ACS_OFS_STATUS: begin
               regRdData <= {14'h0000, status_r};
            end
            `ACS_OFS_MASK: begin
               regRdData <= {14'h0000, mask_r};
            end
            default: begin
               regRdData <= {`ACS_DATA_W{1'b0}};
            end
         endcase
      end else begin
         regRdData <= {`ACS_DATA_W{1'b0}};
      end
   end

endmodule

`default_nettype wire

//--- testbench/acs_adc_ctrl_asserts.sv
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module acs_adc_ctrl_asserts (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [2:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrStb,
   input wire logic        regRdStb,
   input wire logic [15:0] regRdData,
   input wire logic        irq,
   input wire logic        compIn,
   input wire logic [2:0]  chanSel,
   input wire logic [1:0]  refSel,
   input wire logic        sampleHold,
   input wire logic [9:0]  dacCode,
   input wire logic        converterPowered,
   input wire logic [2:0]  sleepMode,
   input wire logic        cpuHalted
);
   // ==========================================================
   // shadow copies of the control bits the properties depend on
   logic enS_r;   // enable bit
   logic freeS_r; // free-running bit
   logic maskS_r; // completion mask bit
   // follow register writes exactly as software issues them
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         enS_r   <= 1'b0;
         freeS_r <= 1'b0;
         maskS_r <= 1'b0;
      end else if (regWrStb && regAddr == 3'h0) begin
         enS_r   <= regWrData[0];
         freeS_r <= regWrData[2];
      end else if (regWrStb && regAddr == 3'h3) begin
         maskS_r <= regWrData[0];
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // converter idle: no trial code and not sampling
   sequence s_idle;
      dacCode == 10'h000 && !sampleHold;
   endsequence
   // the cycle right after a conversion ended
   sequence s_done;
      $past(dacCode) != 10'h000 && dacCode == 10'h000;
   endsequence
   // looked at one cycle after the write, so a back-to-back write cannot hide a wrong mapping
   property p_ref_map;
      regWrStb && regAddr == 3'h0 |=>
         refSel == (($past(regWrData[5:4]) == 2'h1 || $past(regWrData[5:4]) == 2'h3)
                    ? $past(regWrData[5:4]) : 2'h0);
   endproperty
   a_ref_map: assert property (p_ref_map)
      else $error("reference select does not match control field");
   // the free-running restart edge reloads the channel on purpose, so it is left out
   a_chan_hold: assert property ((sampleHold || dacCode != 10'h000) && !$rose(sampleHold)
      && $past(sampleHold || dacCode != 10'h000) |-> $stable(chanSel))
      else $error("channel changed during a conversion");
   a_power_follow: assert property (converterPowered == $past(enS_r))
      else $error("converter power does not follow enable");
   a_sar_msb: assert property ($fell(sampleHold) && enS_r |-> dacCode == 10'h200)
      else $error("first trial code after sampling is wrong");
   a_done_irq: assert property (s_done ##0 (maskS_r && enS_r) |-> irq)
      else $error("completion without interrupt");
   a_sleep_start: assert property ($rose(cpuHalted) && sleepMode < 3'h2 && enS_r && !freeS_r && maskS_r
      ##0 s_idle |-> ##[1:24] sampleHold)
      else $error("halt did not start a conversion");
   a_other_sleep: assert property (cpuHalted && sleepMode > 3'h1 && !$past(regWrStb) |=> $stable(converterPowered))
      else $error("deep sleep changed converter power");
   a_no_resleep: assert property (s_done ##0 (!freeS_r && !cpuHalted && !regWrStb) |=> !sampleHold [*2])
      else $error("conversion restarted on its own");
endmodule
bind acs_adc_ctrl acs_adc_ctrl_asserts acs_adc_ctrl_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
   .irq(irq), .compIn(compIn), .chanSel(chanSel), .refSel(refSel), .sampleHold(sampleHold), .dacCode(dacCode),
   .converterPowered(converterPowered), .sleepMode(sleepMode), .cpuHalted(cpuHalted));
`default_nettype wire

//--- testbench/acs_cpu_model.sv
// behavioural model of the cpu sleep controller and the analog input
`timescale 1ns/1ps
`default_nettype none
module acs_cpu_model (
   input  wire logic       clk_sys,
   input  wire logic       irq,
   input  wire logic [9:0] dacCode,
   output logic            compIn,
   output logic [2:0]      sleepMode,
   output logic            cpuHalted
);
   // ==========================================================
   // analog side: input in code steps, above 0x3FF means over the reference
   logic [10:0] vin = 11'h000;
   // input sits half a step above vin, so a trial at or below vin reads high
   assign compIn = (vin >= {1'b0, dacCode});
   initial begin
      sleepMode = 3'h0;
      cpuHalted = 1'b0;
   end
   // ==========================================================
   // one sleep instruction: halt, then wake on irq or on another source
   task automatic sleep(input logic [2:0] mode, input int wakeAfter);
      int n;
      begin
         n = 0;
         @(posedge clk_sys);
         sleepMode <= mode;
         cpuHalted <= 1'b1;
         @(posedge clk_sys);
         // bounded wait; a short bound stands for another interrupt source
         while (irq !== 1'b1 && n < wakeAfter) begin
            @(posedge clk_sys);
            n++;
         end
         cpuHalted <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ==========================================================
   // stimulus and observed signals
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  regAddr = 3'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrStb = 1'b0;
   logic        regRdStb = 1'b0;
   wire  [15:0] regRdData;
   wire         irq;
   wire         compIn;
   wire  [2:0]  chanSel;
   wire  [1:0]  refSel;
   wire         sampleHold;
   wire  [9:0]  dacCode;
   wire         converterPowered;
   wire  [2:0]  sleepMode;
   wire         cpuHalted;
   int          errors = 0;
   int          checked = 0;
   int          cyc = 0;
   int          i;
   logic [1:0]  refCode [4] = '{2'h1, 2'h3, 2'h2, 2'h0}; // written codes
   logic [1:0]  refExp [4] = '{2'h1, 2'h3, 2'h0, 2'h0};  // unused code falls back to the pin
   acs_adc_ctrl acs_adc_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq), .compIn(compIn),
      .chanSel(chanSel), .refSel(refSel), .sampleHold(sampleHold), .dacCode(dacCode),
      .converterPowered(converterPowered), .sleepMode(sleepMode), .cpuHalted(cpuHalted));
   acs_cpu_model acs_cpu_model_inst (.clk_sys(clk_sys), .irq(irq), .dacCode(dacCode), .compIn(compIn),
      .sleepMode(sleepMode), .cpuHalted(cpuHalted));
   always #2 clk_sys = ~clk_sys;
   // ==========================================================
   // shared tasks; each bus task leaves a gap so strobes never toggle twice in one step
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      begin
         checked++;
         if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
         end
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      begin
         @(posedge clk_sys);
         regAddr   <= a;
         regWrData <= d;
         regWrStb  <= 1'b1;
         @(posedge clk_sys);
         regWrStb  <= 1'b0;
      end
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
      begin
         @(posedge clk_sys);
         regAddr  <= a;
         regRdStb <= 1'b1;
         @(posedge clk_sys);
         regRdStb <= 1'b0;
         #1 chk(regRdData, exp);
      end
   endtask
   // bounded wait for the completion interrupt; the caller judges it
   task automatic waitIrq;
      int n;
      begin
         n = 0;
         while (irq !== 1'b1 && n < 600) begin
            @(posedge clk_sys);
            n++;
         end
         #1;
      end
   endtask
   task automatic print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // hang guard: a full run needs well under a tenth of this
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         $display("unexpected at %0t: run timed out", $time);
         print_verdict;
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdChk(3'h0, 16'h0000);
      rdChk(3'h5, 16'h0000);
      $display("test reset done");
      wr(3'h3, 16'h0001);
      wr(3'h0, 16'h0001);
      acs_cpu_model_inst.vin <= 11'h155;
      wr(3'h0, 16'h0303);
      wr(3'h0, 16'h0501);
      #1 chk(16'(chanSel), 16'h0003);
      waitIrq;
      chk(16'(irq), 16'h0001);
      rdChk(3'h1, 16'h0155);
      wr(3'h2, 16'h0003);
      #1 chk(16'(irq), 16'h0000);
      acs_cpu_model_inst.vin <= 11'h7FF;
      wr(3'h0, 16'h0503);
      waitIrq;
      rdChk(3'h1, 16'h03FF);
      wr(3'h2, 16'h0003);
      $display("test single done");
      for (i = 0; i < 4; i++) begin
         wr(3'h0, {10'h000, refCode[i], 4'h1});
         @(posedge clk_sys);
         #1 chk(16'(refSel), 16'(refExp[i]));
      end
      wr(3'h2, 16'h0003);
      $display("test reference done");
      acs_cpu_model_inst.vin <= 11'h0AA;
      wr(3'h0, 16'h0207);
      waitIrq;
      rdChk(3'h2, 16'h0003);
      wr(3'h2, 16'h0003);
      wr(3'h0, 16'h0605);
      #1 chk(16'(chanSel), 16'h0002);
      waitIrq;
      chk(16'(chanSel), 16'h0006);
      rdChk(3'h1, 16'h00AA);
      wr(3'h2, 16'h0003);
      wr(3'h0, 16'h0601);
      waitIrq;
      wr(3'h2, 16'h0003);
      $display("test free running done");
      acs_cpu_model_inst.vin <= 11'h123;
      for (i = 0; i < 2; i++) begin
         wr(3'h0, 16'h0401);
         acs_cpu_model_inst.sleep(3'(i), 1000);
         #1 chk(16'(irq), 16'h0001);
         chk(16'(chanSel), 16'h0004);
         rdChk(3'h1, 16'h0123);
         wr(3'h2, 16'h0003);
         repeat (40) @(posedge clk_sys);
         rdChk(3'h0, 16'h0401);
      end
      $display("test sleep start done");
      wr(3'h0, 16'h0201);
      acs_cpu_model_inst.sleep(3'h1, 20);
      #1 chk(16'(irq), 16'h0000);
      waitIrq;
      chk(16'(irq), 16'h0001);
      rdChk(3'h1, 16'h0123);
      wr(3'h2, 16'h0003);
      $display("test early wake done");
      acs_cpu_model_inst.sleep(3'h2, 40);
      #1 chk(16'(converterPowered), 16'h0001);
      rdChk(3'h0, 16'h0201);
      wr(3'h0, 16'h0000);
      acs_cpu_model_inst.sleep(3'h3, 40);
      #1 chk(16'(converterPowered), 16'h0000);
      $display("test deep sleep done");
      print_verdict;
   end
endmodule
`default_nettype wire
